// ==== css_pkg.sv ====
// Package for the control source selector: source codes, instance limits,
// AHB-Lite register map and the packed carriers shared by the design files.
// Assumes a 32-bit AHB-Lite slave port and one 100 MHz clock.
package css_pkg;
   localparam int unsigned DW = 32;
   localparam int unsigned SLOTS = 4;
   localparam int unsigned SLOT_W = 2;
   localparam int unsigned TYPE_W = 4;
   localparam int unsigned INST_W = 8;

   typedef enum logic [3:0] {
      SRC_UNUSED = 4'h0, SRC_RX_MSG = 4'h1, SRC_MEAS_IN = 4'h2, SRC_CLOOP = 4'h3,
      SRC_LOOKUP = 4'h4, SRC_LOGIC = 4'h5, SRC_MATH = 4'h6, SRC_CONST = 4'h7,
      SRC_FAULT = 4'h8, SRC_OUT_TGT = 4'h9, SRC_OUT_CUR = 4'hA, SRC_OUT_VOLT = 4'hB,
      SRC_SUPPLY = 4'hC, SRC_TEMP = 4'hD, SRC_RX_TMO = 4'hE, SRC_VREF = 4'hF
   } css_src_t;

   // Instance limits per source class
   localparam logic [7:0] INST_ONE = 8'h01;
   localparam logic [7:0] INST_MAX5 = 8'h05;
   localparam logic [7:0] INST_MAX4 = 8'h04;
   localparam logic [7:0] INST_MAX14 = 8'h0E;
   localparam logic [7:0] INST_MAX2 = 8'h02;
   localparam logic [7:0] INST_CUR_LO = 8'h01;
   localparam logic [7:0] INST_CUR_HI = 8'h02;
   localparam logic [7:0] INST_VLT_LO = 8'h03;
   localparam logic [7:0] INST_VLT_HI = 8'h04;
   localparam logic [7:0] INST_TRUE = 8'h02;
   localparam logic [7:0] INST_USER_LO = 8'h03;
   localparam int unsigned NUSER = 12;

   // Reference check: value*10 > nominal*9 means above 90 percent
   localparam logic [7:0] VREF_NUM = 8'h09;
   localparam logic [7:0] VREF_DEN = 8'h0A;

   // Register map, byte addresses
   localparam logic [11:0] A_SEL_BASE = 12'h000;
   localparam logic [11:0] A_MIN_BASE = 12'h010;
   localparam logic [11:0] A_MAX_BASE = 12'h020;
   localparam logic [11:0] A_OUT_BASE = 12'h030;
   localparam logic [11:0] A_DIG = 12'h040;
   localparam logic [11:0] A_CONST_BASE = 12'h080;
   localparam logic [11:0] A_FSPN_BASE = 12'h0C0;
   localparam logic [11:0] A_VNOM_BASE = 12'h0E0;
   localparam logic [31:0] SEL_RST = 32'h0000_0000;

   // Select register fields
   localparam int unsigned F_TYPE_LO = 0;
   localparam int unsigned F_INST_LO = 8;
   localparam int unsigned F_DMODE = 16;
   localparam int unsigned F_OUTBLK = 17;

   typedef struct packed {
      logic [3:0] typ;
      logic [7:0] inst;
      logic dmode;
      logic outblk;
   } css_sel_t;

   // Live values from the rest of the controller
   typedef struct packed {
      logic [4:0][31:0] rx_msg;
      logic [3:0][31:0] meas_in;
      logic [3:0][31:0] cloop;
      logic [3:0][31:0] lookup;
      logic [3:0][31:0] logic_blk;
      logic [3:0][31:0] math;
      logic [4:0] fault_act;
      logic [4:0][31:0] out_tgt;
      logic [1:0][31:0] out_cur;
      logic [1:0][31:0] out_volt;
      logic [31:0] supply;
      logic [31:0] temp;
      logic rx_tmo;
      logic [1:0][31:0] vref;
   } css_live_t;

   typedef struct packed {
      logic [31:0] value;
      logic valid;
      logic digital;
   } css_res_t;
endpackage : css_pkg

// ==== css_hyst.sv ====
// One slot's analog to on/off conversion with hysteresis.
// Assumes min and max come from software and value is a settled signed sample.
`timescale 1ns/1ns
`default_nettype none
module css_hyst (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Sample and thresholds
   input wire logic en,
   input wire logic signed [31:0] value,
   input wire logic signed [31:0] lo,
   input wire logic signed [31:0] hi,
   // Result
   output logic state
);
   typedef struct packed {
      logic st;
   } css_hyst_st_t;
   css_hyst_st_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (!en) begin
         s_nxt.st = 1'b0;
      end else if (value >= hi) begin
         s_nxt.st = 1'b1;
      end else if (value <= lo) begin
         s_nxt.st = 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign state = s_r.st;
endmodule : css_hyst
`default_nettype wire

// ==== css_decode.sv ====
// Combinational source decode: type and instance pick one live value.
// Assumes all live values are held steady by their producers.
`timescale 1ns/1ns
`default_nettype none
module css_decode (
   // Selection
   input wire css_pkg::css_sel_t sel,
   // Live sources and user constants
   input wire css_pkg::css_live_t live,
   input wire logic [11:0][31:0] user_const,
   input wire logic [4:0][31:0] fault_spn,
   input wire logic [1:0][31:0] vref_nom,
   // Result
   output css_pkg::css_res_t res
);
   logic [7:0] i;
   logic [7:0] k;
   always_comb begin
      i = sel.inst;
      k = i - css_pkg::INST_ONE;
      res = '0;
      case (sel.typ)
         css_pkg::SRC_RX_MSG: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX5) begin
            res.value = live.rx_msg[k[2:0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_MEAS_IN: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX4) begin
            res.value = live.meas_in[k[1:0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_CLOOP: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX4) begin
            res.value = live.cloop[k[1:0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_LOOKUP: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX4) begin
            res.value = live.lookup[k[1:0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_LOGIC: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX4) begin
            res.value = live.logic_blk[k[1:0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_MATH: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX4) begin
            res.value = live.math[k[1:0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_CONST: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX14) begin
            res.valid = 1'b1;
            if (i == css_pkg::INST_ONE) begin
               res.value = '0;
               res.digital = 1'b1;
            end else if (i == css_pkg::INST_TRUE) begin
               res.value = 32'h0000_0001;
               res.digital = 1'b1;
            end else begin
               res.value = user_const[4'(i - css_pkg::INST_USER_LO)];
            end
         end
         css_pkg::SRC_FAULT: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX5
                                 && fault_spn[k[2:0]] != '0) begin
            res.value = {31'h0, live.fault_act[k[2:0]]};
            res.valid = 1'b1;
            res.digital = 1'b1;
         end
         css_pkg::SRC_OUT_TGT: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX5) begin
            res.value = live.out_tgt[k[2:0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_OUT_CUR: if (i >= css_pkg::INST_CUR_LO && i <= css_pkg::INST_CUR_HI) begin
            res.value = live.out_cur[k[0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_OUT_VOLT: if (i >= css_pkg::INST_VLT_LO && i <= css_pkg::INST_VLT_HI) begin
            res.value = live.out_volt[k[0]];
            res.valid = 1'b1;
         end
         css_pkg::SRC_SUPPLY: begin
            res.value = {31'h0, $signed(live.supply) >= $signed({24'h0, i})};
            res.valid = 1'b1;
            res.digital = 1'b1;
         end
         css_pkg::SRC_TEMP: begin
            res.value = {31'h0, $signed(live.temp) >= $signed({24'h0, i})};
            res.valid = 1'b1;
            res.digital = 1'b1;
         end
         css_pkg::SRC_RX_TMO: if (sel.outblk) begin
            res.value = {31'h0, live.rx_tmo};
            res.valid = 1'b1;
            res.digital = 1'b1;
         end
         css_pkg::SRC_VREF: if (i >= css_pkg::INST_ONE && i <= css_pkg::INST_MAX2) begin
            res.value = {31'h0, 36'(live.vref[k[0]]) * 36'(css_pkg::VREF_DEN)
                               > 36'(vref_nom[k[0]]) * 36'(css_pkg::VREF_NUM)};
            res.valid = 1'b1;
            res.digital = 1'b1;
         end
         default: res = '0;
      endcase
   end
endmodule : css_decode
`default_nettype wire

// ==== css_top.sv ====
// Control source selector: per-slot type/instance selection, digital
// conversion with hysteresis, AHB-Lite register slave.
// Assumes a single 100 MHz clock and a master that issues single word transfers.
// Summary of operation
// - Each slot holds a four-bit source type from 0 to 15.
// - Each slot holds an instance number choosing one source of that type.
// - Type zero means the slot is unused and its other settings are ignored.
// - Received messages take instances 1-5; measured, closed-loop, lookup, logic, math 1-4.
// - Constants take 1-14: 1 is false, 2 is true, 3-14 are user values.
// - Fault codes take 1-5 and count only when their suspect number is non-zero.
// - Output feedback gives target 1-5, current 1-2 and signal voltage 3-4.
// - Supply and temperature use the instance 0-255 as a compare threshold.
// - Reception timeout, type 14, is selectable only by output blocks.
// - Reference sources 1-2 give one above 90 percent of nominal, else zero.
// - Analog into a digital-mode slot goes off at or below min, on at or above max.
// - Measured inputs as digital are on at or above max range, off at or below min.
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module css_top #(
   parameter int unsigned N_SLOT = css_pkg::SLOTS
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Live sources
   input wire css_pkg::css_live_t live,
   // Per-slot outputs to the consuming blocks
   output logic [N_SLOT-1:0][31:0] slot_value,
   output logic [N_SLOT-1:0] slot_valid
);
   typedef struct packed {
      logic [N_SLOT-1:0][31:0] sel;
      logic [N_SLOT-1:0][31:0] lo;
      logic [N_SLOT-1:0][31:0] hi;
      logic [11:0][31:0] ucon;
      logic [4:0][31:0] fspn;
      logic [1:0][31:0] vnom;
      logic [N_SLOT-1:0][31:0] val;
      logic [N_SLOT-1:0] vld;
      logic wpend;
      logic [11:0] waddr;
      logic [31:0] rdata;
   } css_st_t;

   css_st_t s_r, s_nxt;
   css_pkg::css_res_t res [N_SLOT];
   logic [N_SLOT-1:0] hyst;
   logic [N_SLOT-1:0] hen;
   css_pkg::css_sel_t sel [N_SLOT];

   genvar g;
   generate
      for (g = 0; g < N_SLOT; g++) begin : g_slot
         assign sel[g].typ = s_r.sel[g][css_pkg::F_TYPE_LO +: css_pkg::TYPE_W];
         assign sel[g].inst = s_r.sel[g][css_pkg::F_INST_LO +: css_pkg::INST_W];
         assign sel[g].dmode = s_r.sel[g][css_pkg::F_DMODE];
         assign sel[g].outblk = s_r.sel[g][css_pkg::F_OUTBLK];
         css_decode u_dec (
            .sel(sel[g]),
            .live(live),
            .user_const(s_r.ucon),
            .fault_spn(s_r.fspn),
            .vref_nom(s_r.vnom),
            .res(res[g])
         );
         // Hysteresis only when an analog source feeds a digital-mode slot
         assign hen[g] = sel[g].dmode && res[g].valid && !res[g].digital;
         css_hyst u_hyst (
            .clock(clock),
            .rst(rst),
            .en(hen[g]),
            .value(res[g].value),
            .lo(s_r.lo[g]),
            .hi(s_r.hi[g]),
            .state(hyst[g])
         );
      end
   endgenerate

   logic acc;
   logic [11:0] a;
   logic [5:0] wi;
   logic [3:0] fld;
   logic [31:0] rd;
   always_comb begin
      s_nxt = s_r;
      acc = hsel && hready && htrans[1];
      a = haddr[11:0];
      wi = s_r.waddr[7:2];
      rd = '0;
      // Register read mux, word index decode
      if (a[11:4] == css_pkg::A_SEL_BASE[11:4] && a[3:2] < N_SLOT) begin
         rd = s_r.sel[a[3:2]];
      end else if (a[11:4] == css_pkg::A_MIN_BASE[11:4] && a[3:2] < N_SLOT) begin
         rd = s_r.lo[a[3:2]];
      end else if (a[11:4] == css_pkg::A_MAX_BASE[11:4] && a[3:2] < N_SLOT) begin
         rd = s_r.hi[a[3:2]];
      end else if (a[11:4] == css_pkg::A_OUT_BASE[11:4] && a[3:2] < N_SLOT) begin
         rd = s_r.val[a[3:2]];
      end else if (a == css_pkg::A_DIG) begin
         rd = 32'(s_r.vld);
      end else if (a[11:6] == css_pkg::A_CONST_BASE[11:6] && a[5:2] < css_pkg::NUSER) begin
         rd = s_r.ucon[a[5:2]];
      end else if (a[11:5] == css_pkg::A_FSPN_BASE[11:5] && a[4:2] < css_pkg::INST_MAX5) begin
         rd = s_r.fspn[a[4:2]];
      end else if (a[11:3] == css_pkg::A_VNOM_BASE[11:3]) begin
         rd = s_r.vnom[a[2]];
      end
      if (acc && !hwrite) begin
         s_nxt.rdata = rd;
      end
      s_nxt.wpend = acc && hwrite;
      if (acc && hwrite) begin
         s_nxt.waddr = a;
      end
      // Write data phase; unmapped writes are dropped
      if (s_r.wpend) begin
         fld = wi[3:0];
         if (s_r.waddr[11:4] == css_pkg::A_SEL_BASE[11:4] && wi[1:0] < N_SLOT) begin
            s_nxt.sel[wi[1:0]] = hwdata;
         end else if (s_r.waddr[11:4] == css_pkg::A_MIN_BASE[11:4] && wi[1:0] < N_SLOT) begin
            s_nxt.lo[wi[1:0]] = hwdata;
         end else if (s_r.waddr[11:4] == css_pkg::A_MAX_BASE[11:4] && wi[1:0] < N_SLOT) begin
            s_nxt.hi[wi[1:0]] = hwdata;
         end else if (s_r.waddr[11:6] == css_pkg::A_CONST_BASE[11:6] && fld < css_pkg::NUSER) begin
            s_nxt.ucon[fld] = hwdata;
         end else if (s_r.waddr[11:5] == css_pkg::A_FSPN_BASE[11:5]
                      && wi[2:0] < css_pkg::INST_MAX5) begin
            s_nxt.fspn[wi[2:0]] = hwdata;
         end else if (s_r.waddr[11:3] == css_pkg::A_VNOM_BASE[11:3]) begin
            s_nxt.vnom[wi[0]] = hwdata;
         end
      end else begin
         fld = '0;
      end
      // Slot results, registered
      for (int n = 0; n < N_SLOT; n++) begin
         if (!res[n].valid) begin
            s_nxt.val[n] = '0;
            s_nxt.vld[n] = 1'b0;
         end else if (sel[n].dmode && !res[n].digital) begin
            s_nxt.val[n] = {31'h0, hyst[n]};
            s_nxt.vld[n] = 1'b1;
         end else begin
            s_nxt.val[n] = res[n].value;
            s_nxt.vld[n] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata = s_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign slot_value = s_r.val;
   assign slot_valid = s_r.vld;
endmodule : css_top
`default_nettype wire

// ==== css_src_model.sv ====
// Far-side model: the controller blocks that feed the selector with live values.
// Assumes the bench moves base and the flag inputs just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module css_src_model (
   // Stimulus from the bench
   input wire logic [31:0] base,
   input wire logic [4:0] fault_bits,
   input wire logic tmo,
   input wire logic [1:0][31:0] vref_lvl,
   // Live sources
   output css_pkg::css_live_t live
);
   // Class code in bits 7:4 and instance minus one (minus three for signal voltage) in bits 3:0, added to base, so a wrong pick shows as a wrong value
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         live.rx_msg[i] = base + 32'h0000_0010 + 32'(i);
         live.out_tgt[i] = base + 32'h0000_0090 + 32'(i);
      end
      for (int i = 0; i < 4; i++) begin
         live.meas_in[i] = base + 32'h0000_0020 + 32'(i);
         live.cloop[i] = base + 32'h0000_0030 + 32'(i);
         live.lookup[i] = base + 32'h0000_0040 + 32'(i);
         live.logic_blk[i] = base + 32'h0000_0050 + 32'(i);
         live.math[i] = base + 32'h0000_0060 + 32'(i);
      end
      for (int i = 0; i < 2; i++) begin
         live.out_cur[i] = base + 32'h0000_00A0 + 32'(i);
         live.out_volt[i] = base + 32'h0000_00B0 + 32'(i);
      end
      live.supply = base;
      live.temp = base + 32'h0000_0001;
      live.fault_act = fault_bits;
      live.rx_tmo = tmo;
      live.vref = vref_lvl;
   end
endmodule : css_src_model
`default_nettype wire

// ==== css_top_sva.sv ====
// Checker for the selector: bus answer and slot 0 results after select writes.
// Assumes the select of slot 0 is not written again within two cycles of a write.
`timescale 1ns/1ns
`default_nettype none
module css_chk #(
   parameter int unsigned N_SLOT = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // Slot results
   input wire logic [N_SLOT-1:0][31:0] slot_value,
   input wire logic [N_SLOT-1:0] slot_valid
);
   logic taken;
   logic sel0_wr;
   assign taken = hsel && hready && htrans[1];
   assign sel0_wr = taken && hwrite && (haddr[11:0] == 12'h000);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   AST_READY: assert property (hreadyout)
      else $error("hreadyout low");
   AST_OKAY: assert property (!hresp)
      else $error("hresp not OKAY");
   AST_UNUSED: assert property (sel0_wr ##1 (hwdata[3:0] == 4'h0) |->
      ##2 (!slot_valid[0] && slot_value[0] == 32'h0)) else $error("unused slot not cleared");
   AST_TRUE: assert property (sel0_wr ##1 (hwdata[17:0] == 18'h207) |->
      ##2 (slot_valid[0] && slot_value[0] == 32'h1)) else $error("constant true wrong");
   AST_FALSE: assert property (sel0_wr ##1 (hwdata[17:0] == 18'h107) |->
      ##2 (slot_valid[0] && slot_value[0] == 32'h0)) else $error("constant false wrong");
   AST_RANGE: assert property (sel0_wr ##1 (hwdata[15:0] == 16'h0601) |->
      ##2 (!slot_valid[0] && slot_value[0] == 32'h0)) else $error("bad instance accepted");
   AST_TMO: assert property (sel0_wr ##1 (hwdata[3:0] == 4'hE && !hwdata[17]) |->
      ##2 !slot_valid[0]) else $error("timeout on non-output slot");
   AST_RDVALID: assert property (taken && !hwrite && haddr[11:0] == 12'h040 |=>
      hrdata == 32'($past(slot_valid))) else $error("valid register wrong");
   AST_RDVAL: assert property (taken && !hwrite && haddr[11:0] == 12'h030 |=>
      hrdata == $past(slot_value[0])) else $error("value register wrong");
endmodule : css_chk
bind css_top css_chk #(.N_SLOT(N_SLOT)) u_css_chk (.clock(clock), .rst(rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .slot_value(slot_value),
   .slot_valid(slot_valid));
`default_nettype wire

// ==== tb_control_source_selector.sv ====
// Bench for the selector: AHB-Lite writes pick sources, results read at the slot ports.
// Assumes the far-side model values base plus class and instance codes.
`timescale 1ns/1ns
`default_nettype none
module tb_control_source_selector;
   localparam logic [31:0] B = 32'h0000_0040;
   logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, tmo;
   logic [31:0] haddr, hwdata, hrdata, base, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] fault_bits;
   logic [1:0][31:0] vref_lvl;
   logic [7:0] mx;
   css_pkg::css_live_t live;
   logic [3:0][31:0] slot_value;
   logic [3:0] slot_valid;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   assign hready = hreadyout;
   css_src_model u_css_src_model (.base(base), .fault_bits(fault_bits), .tmo(tmo),
      .vref_lvl(vref_lvl), .live(live));
   css_top #(.N_SLOT(4)) u_css_top (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .live(live),
      .slot_value(slot_value), .slot_valid(slot_valid));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic final_report();
      if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, s);
         n_fail++;
      end
   endtask : cmp
   // One single word transfer; entered just after a rising edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   // Four edges cover the select path plus the hysteresis stage
   task automatic wchk(input logic [1:0] i, input logic [31:0] ev, input logic ex);
      repeat (4) @(posedge clock);
      #1;
      cmp("slot_value", ev, slot_value[i]);
      cmp("slot_valid", {31'h0, ex}, {31'h0, slot_valid[i]});
      @(posedge clock);
   endtask : wchk
   task automatic cs(input logic [11:0] a, input logic [3:0] t, input logic [7:0] n,
                     input logic ob, input logic dm, input logic [31:0] ev, input logic ex);
      logic [31:0] r;
      bus(1'b1, a, {14'h0, ob, dm, n, 4'h0, t}, r);
      wchk(a[3:2], ev, ex);
   endtask : cs
   task automatic hy(input logic [31:0] b, input logic [31:0] ev);
      base <= b;
      wchk(2'h0, ev, 1'b1);
   endtask : hy
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         final_report();
      end
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      base = B;
      fault_bits = 5'h01;
      tmo = 1'b1;
      vref_lvl = {32'h0000_005A, 32'h0000_005B};
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      cmp("rst_value", 32'h0, slot_value[0]);
      cmp("rst_valid", 32'h0, {28'h0, slot_valid});
      @(posedge clock);
      bus(1'b0, 12'h100, 32'h0, q);
      cmp("unmapped", 32'h0, q);
      bus(1'b1, 12'h080, 32'h1234_5678, q);
      bus(1'b1, 12'h0AC, 32'h0BAD_F00D, q);
      bus(1'b1, 12'h0C0, 32'h0000_00AB, q);
      bus(1'b1, 12'h0C4, 32'h0, q);
      bus(1'b1, 12'h0E0, 32'h0000_0064, q);
      bus(1'b1, 12'h0E4, 32'h0000_0064, q);
      cs(12'h000, 4'h0, 8'h01, 1'b0, 1'b1, 32'h0, 1'b0);
      for (int t = 1; t <= 6; t++) begin
         mx = (t == 1) ? 8'h05 : 8'h04;
         cs(12'h000, 4'(t), mx, 1'b0, 1'b0, B + 32'(t * 16) + 32'(mx) - 32'h1, 1'b1);
         cs(12'h000, 4'(t), mx + 8'h01, 1'b0, 1'b0, 32'h0, 1'b0);
         cs(12'h000, 4'(t), 8'h00, 1'b0, 1'b0, 32'h0, 1'b0);
      end
      cs(12'h000, 4'h9, 8'h05, 1'b0, 1'b0, B + 32'h94, 1'b1);
      cs(12'h000, 4'h9, 8'h06, 1'b0, 1'b0, 32'h0, 1'b0);
      cs(12'h000, 4'hA, 8'h01, 1'b0, 1'b0, B + 32'hA0, 1'b1);
      cs(12'h000, 4'hA, 8'h02, 1'b0, 1'b0, B + 32'hA1, 1'b1);
      cs(12'h000, 4'hA, 8'h03, 1'b0, 1'b0, 32'h0, 1'b0);
      cs(12'h000, 4'hB, 8'h03, 1'b0, 1'b0, B + 32'hB0, 1'b1);
      cs(12'h000, 4'hB, 8'h04, 1'b0, 1'b0, B + 32'hB1, 1'b1);
      cs(12'h000, 4'hB, 8'h02, 1'b0, 1'b0, 32'h0, 1'b0);
      cs(12'h000, 4'h7, 8'h01, 1'b0, 1'b0, 32'h0, 1'b1);
      cs(12'h000, 4'h7, 8'h02, 1'b0, 1'b0, 32'h1, 1'b1);
      // A digital source in a digital-mode slot bypasses the hysteresis stage
      cs(12'h000, 4'h7, 8'h02, 1'b0, 1'b1, 32'h1, 1'b1);
      bus(1'b0, 12'h030, 32'h0, q);
      cmp("value_reg", 32'h1, q);
      cs(12'h000, 4'h7, 8'h03, 1'b0, 1'b0, 32'h1234_5678, 1'b1);
      cs(12'h000, 4'h7, 8'h0E, 1'b0, 1'b0, 32'h0BAD_F00D, 1'b1);
      cs(12'h000, 4'h7, 8'h0F, 1'b0, 1'b0, 32'h0, 1'b0);
      cs(12'h000, 4'h8, 8'h01, 1'b0, 1'b0, 32'h1, 1'b1);
      cs(12'h000, 4'h8, 8'h02, 1'b0, 1'b0, 32'h0, 1'b0);
      cs(12'h000, 4'h8, 8'h06, 1'b0, 1'b0, 32'h0, 1'b0);
      cs(12'h000, 4'hC, 8'h40, 1'b0, 1'b0, 32'h1, 1'b1);
      cs(12'h000, 4'hC, 8'h41, 1'b0, 1'b0, 32'h0, 1'b1);
      cs(12'h000, 4'hD, 8'h41, 1'b0, 1'b0, 32'h1, 1'b1);
      cs(12'h000, 4'hD, 8'h42, 1'b0, 1'b0, 32'h0, 1'b1);
      cs(12'h000, 4'hE, 8'h00, 1'b1, 1'b0, 32'h1, 1'b1);
      cs(12'h000, 4'hE, 8'h00, 1'b0, 1'b0, 32'h0, 1'b0);
      cs(12'h000, 4'hF, 8'h01, 1'b0, 1'b0, 32'h1, 1'b1);
      cs(12'h000, 4'hF, 8'h02, 1'b0, 1'b0, 32'h0, 1'b1);
      cs(12'h000, 4'hF, 8'h03, 1'b0, 1'b0, 32'h0, 1'b0);
      cs(12'h004, 4'h7, 8'h02, 1'b0, 1'b0, 32'h1, 1'b1);
      bus(1'b0, 12'h040, 32'h0, q);
      cmp("valid_reg", 32'h2, q);
      cs(12'h004, 4'h0, 8'h02, 1'b0, 1'b1, 32'h0, 1'b0);
      bus(1'b1, 12'h010, 32'h0000_0030, q);
      bus(1'b1, 12'h020, 32'h0000_0050, q);
      base <= 32'h0;
      cs(12'h000, 4'h2, 8'h01, 1'b0, 1'b1, 32'h0, 1'b1);
      hy(32'h0000_0020, 32'h0);
      hy(32'h0000_0030, 32'h1);
      hy(32'h0000_0020, 32'h1);
      hy(32'h0000_0010, 32'h0);
      final_report();
   end
endmodule : tb_control_source_selector
`default_nettype wire
